// ### inc/fault_log_min_defines.vh
// Constants for the fault log and minimum telemetry register group
`ifndef FAULT_LOG_MIN_DEFINES_VH
`define FAULT_LOG_MIN_DEFINES_VH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define CMD_CLEAR_FAULTS     8'h03
`define CMD_STORE_USER_ALL   8'h15
`define CMD_RESTORE_USER_ALL 8'h16
`define CMD_SPARE_0          8'hB0
`define CMD_SPARE_1          8'hB1
`define CMD_SPARE_2          8'hB2
`define CMD_SPARE_3          8'hB3
`define CMD_FACTORY_LOT      8'hB4
`define CMD_OFF_THRESH_COEF  8'hB5
`define CMD_SHARED_PIN_STAT  8'hB6
`define CMD_VOUT_MINIMUM     8'hB7
`define CMD_VIN_MINIMUM      8'hB8
`define CMD_TEMP_MINIMUM     8'hB9
`define CMD_FLOG_STORE       8'hBA
`define CMD_FLOG_RESTORE     8'hBB
`define CMD_FLOG_CLEAR       8'hBC
`define CMD_FLOG_STATUS      8'hBD

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SHARED_WP_BIT        0
`define SHARED_CLK_LOW_BIT   1
`define FLOG_EEPROM_BIT      0
`define FLOG_RAM_BIT         1

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define VOUT_MIN_RESET       16'hFFFF
`define L11_MIN_RESET        16'h7BFF
`define COEF_RESET           16'hF801
`define VOUT_LAST_RESET      16'hFFFF
`define UNSUPPORTED_VALUE    16'h0000
`define FACTORY_LOT_VALUE    8'h5A
`define ADC_SEL_VIN          4'h8
`define ADC_SEL_TEMP         4'h9
`define SPARE_WORDS          18

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define REF_CLK_NS           20
`define SHARE_LOW_NS         1000
`define SHARE_LOW_CYC        ((`SHARE_LOW_NS + `REF_CLK_NS - 1) / `REF_CLK_NS)

`endif

// ### design/pin_sync.v
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module pin_sync #(
  parameter W = 2
) (
  input  wire         ref_clk,
  input  wire         rst_b,
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] pin_sync_out
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      // First stage feeds only the second stage
      always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= pin_in[i];
          sync_reg <= meta_reg;
        end
      end
      assign pin_sync_out[i] = sync_reg;
    end
  endgenerate

endmodule

// ### design/fault_log_and_min_telemetry.v
// Fault log control, discharge check and minimum telemetry registers
`timescale 1ns/10ps
`include "fault_log_min_defines.vh"

module fault_log_and_min_telemetry (
  input  wire         ref_clk,
  input  wire         rst_b,
  input  wire         cmd_valid,
  input  wire         cmd_write,
  input  wire [7:0]   cmd_code,
  input  wire [2:0]   cmd_page,
  input  wire [15:0]  cmd_wdata,
  output reg          rsp_valid,
  output reg  [15:0]  rsp_data,
  output reg          rsp_error,
  input  wire         share_clk_pin,
  input  wire         write_protect_pin,
  input  wire         adc_valid,
  input  wire [3:0]   adc_sel,
  input  wire [15:0]  adc_data,
  input  wire [127:0] vout_cmd_bus,
  input  wire [7:0]   uv_enable,
  input  wire [7:0]   current_mode,
  input  wire         vin_off,
  input  wire [7:0]   on_cmd,
  input  wire [7:0]   off_cmd,
  output wire [7:0]   chan_on,
  output wire [7:0]   discharge_status,
  output reg          alert_n,
  input  wire         fault_latch_off,
  input  wire         fault_log_enable,
  input  wire         fault_log_read_done,
  output reg          ram_log_we,
  output reg          ee_write_req,
  output reg          ee_read_req,
  output reg          ee_erase_req
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_OFF  = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_ON   = 2'b10;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg  [15:0] coef_reg      [0:7];
  reg  [15:0] vout_last_reg [0:7];
  reg  [15:0] vout_min_reg  [0:7];
  reg  [15:0] spare_reg     [0:`SPARE_WORDS-1];
  reg  [15:0] spare_nv_reg  [0:`SPARE_WORDS-1];
  reg  [15:0] vin_min_reg;
  reg  [15:0] temp_min_reg;
  reg         ee_status_reg;
  reg         ram_lock_reg;
  reg  [15:0] share_cnt_reg;
  reg         share_low_reg;
  reg  [15:0] rd_next;
  reg         err_next;
  reg  [4:0]  spare_idx;
  integer     k;

  wire [1:0]  pins_sync;
  wire        share_s = pins_sync[0];
  wire        wp_s    = pins_sync[1];

  wire        cmd_wr    = cmd_valid & cmd_write;
  wire        clr_fault = cmd_valid & ~cmd_write & (cmd_code == `CMD_CLEAR_FAULTS);
  wire        fl_store  = cmd_valid & ~cmd_write & (cmd_code == `CMD_FLOG_STORE);
  wire        fl_rest   = cmd_valid & ~cmd_write & (cmd_code == `CMD_FLOG_RESTORE);
  wire        fl_clear  = cmd_valid & ~cmd_write & (cmd_code == `CMD_FLOG_CLEAR);
  wire        usr_store = cmd_valid & ~cmd_write & (cmd_code == `CMD_STORE_USER_ALL);
  wire        usr_rest  = cmd_valid & ~cmd_write & (cmd_code == `CMD_RESTORE_USER_ALL);

  // Latch-off faults and store commands are the only transfer causes
  wire        xfer_go   = (fault_latch_off | fl_store) & fault_log_enable & ~ee_status_reg;

  // Converts an L11 value to fixed point with 16 fraction bits
  function signed [63:0] l11_fix;
    input [15:0] v;
    reg signed [63:0] m;
    begin
      m = {{53{v[10]}}, v[10:0]};
      l11_fix = m <<< {~v[15], v[14:11]};
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  pin_sync #(
    .W (2)
  ) u_pin_sync (
    .ref_clk      (ref_clk),
    .rst_b        (rst_b),
    .pin_in       ({write_protect_pin, share_clk_pin}),
    .pin_sync_out (pins_sync)
  );

  // ----------------------------------------------------------------
  // Share clock held-low detector
  // ----------------------------------------------------------------
  // A low that outlasts several link periods counts as held low
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      share_cnt_reg  <= 16'h0000;
      share_low_reg  <= 1'b0;
    end else begin
      if (share_s) begin
        share_cnt_reg <= 16'h0000;
        share_low_reg <= 1'b0;
      end else if (share_cnt_reg >= `SHARE_LOW_CYC - 1) begin
        share_low_reg <= 1'b1;
      end else begin
        share_cnt_reg <= share_cnt_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-channel discharge check
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_chan
      reg  [1:0]         st_reg;
      reg                on_reg;
      reg                disch_reg;
      wire [15:0]        vcmd = vout_cmd_bus[16*i+15:16*i];
      wire [15:0]        coef = coef_reg[i];
      wire signed [27:0] prod = $signed({1'b0, vcmd}) * $signed(coef[10:0]);
      wire signed [63:0] thr  = $signed({{36{prod[27]}}, prod}) <<< {~coef[15], coef[14:11]};
      wire signed [63:0] meas = $signed({32'h0000_0000, vout_last_reg[i], 16'h0000});
      wire signed [63:0] vref = $signed({32'h0000_0000, vcmd, 16'h0000});
      wire               disabled = thr > vref;
      wire               above    = (meas >= thr) & ~disabled;
      wire               ev       = on_cmd[i] & above;

      always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          st_reg    <= ST_OFF;
          on_reg    <= 1'b0;
          disch_reg <= 1'b0;
        end else begin
          if (ev)
            disch_reg <= 1'b1;
          else if (clr_fault)
            disch_reg <= 1'b0;
          case (st_reg)
            ST_OFF, ST_ON: begin
              if (on_cmd[i]) begin
                st_reg <= above ? ST_WAIT : ST_ON;
                on_reg <= ~above;
              end else if (off_cmd[i]) begin
                st_reg <= ST_OFF;
                on_reg <= 1'b0;
              end
            end
            ST_WAIT: begin
              if (off_cmd[i]) begin
                st_reg <= ST_OFF;
              end else if (~above) begin
                st_reg <= ST_ON;
                on_reg <= 1'b1;
              end
            end
            default: begin
              st_reg <= ST_OFF;
              on_reg <= 1'b0;
            end
          endcase
        end
      end
      assign chan_on[i]          = on_reg;
      assign discharge_status[i] = disch_reg;
    end
  endgenerate

  // Alert stays low while any discharge flag stands
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
      alert_n <= 1'b1;
    else
      alert_n <= ~(|discharge_status);
  end

  // ----------------------------------------------------------------
  // Telemetry minimums and last readings
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (k = 0; k < 8; k = k + 1) begin
        vout_min_reg[k]  <= `VOUT_MIN_RESET;
        vout_last_reg[k] <= `VOUT_LAST_RESET;
      end
      vin_min_reg  <= `L11_MIN_RESET;
      temp_min_reg <= `L11_MIN_RESET;
    end else if (clr_fault) begin
      for (k = 0; k < 8; k = k + 1)
        vout_min_reg[k] <= `VOUT_MIN_RESET;
      vin_min_reg  <= `L11_MIN_RESET;
      temp_min_reg <= `L11_MIN_RESET;
    end else if (adc_valid) begin
      if (adc_sel < 4'h8) begin
        vout_last_reg[adc_sel[2:0]] <= adc_data;
        // Unsigned L16 compare; odd current channels carry no voltage
        if (uv_enable[adc_sel[2:0]] & ~(adc_sel[0] & current_mode[adc_sel[2:0]]) &
            (adc_data < vout_min_reg[adc_sel[2:0]]))
          vout_min_reg[adc_sel[2:0]] <= adc_data;
      end else if (adc_sel == `ADC_SEL_VIN) begin
        if (~vin_off && (l11_fix(adc_data) < l11_fix(vin_min_reg)))
          vin_min_reg <= adc_data;
      end else if (adc_sel == `ADC_SEL_TEMP) begin
        if (l11_fix(adc_data) < l11_fix(temp_min_reg))
          temp_min_reg <= adc_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Writable registers and spare words
  // ----------------------------------------------------------------
  always @* begin
    case (cmd_code)
      `CMD_SPARE_0: spare_idx = 5'd0;
      `CMD_SPARE_1: spare_idx = 5'd1;
      `CMD_SPARE_2: spare_idx = 5'd2 + {2'b00, cmd_page};
      default:      spare_idx = 5'd10 + {2'b00, cmd_page};
    endcase
  end

  wire spare_hit = (cmd_code == `CMD_SPARE_0) | (cmd_code == `CMD_SPARE_1) |
                   (cmd_code == `CMD_SPARE_2) | (cmd_code == `CMD_SPARE_3);

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (k = 0; k < 8; k = k + 1)
        coef_reg[k] <= `COEF_RESET;
      for (k = 0; k < `SPARE_WORDS; k = k + 1) begin
        spare_reg[k]    <= 16'h0000;
        spare_nv_reg[k] <= 16'h0000;
      end
    end else begin
      if (cmd_wr && cmd_code == `CMD_OFF_THRESH_COEF)
        coef_reg[cmd_page] <= cmd_wdata;
      if (cmd_wr && spare_hit)
        spare_reg[spare_idx] <= cmd_wdata;
      // Non-volatile image is copied whole; a write in the same cycle is lost
      if (usr_store)
        for (k = 0; k < `SPARE_WORDS; k = k + 1)
          spare_nv_reg[k] <= spare_reg[k];
      else if (usr_rest)
        for (k = 0; k < `SPARE_WORDS; k = k + 1)
          spare_reg[k] <= spare_nv_reg[k];
    end
  end

  // ----------------------------------------------------------------
  // Fault log control
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ee_status_reg <= 1'b0;
      ram_lock_reg  <= 1'b0;
      ram_log_we    <= 1'b0;
      ee_write_req  <= 1'b0;
      ee_read_req   <= 1'b0;
      ee_erase_req  <= 1'b0;
    end else begin
      ram_log_we   <= adc_valid & ~ram_lock_reg;
      ee_write_req <= xfer_go;
      ee_read_req  <= fl_rest;
      ee_erase_req <= fl_clear;
      // A transfer landing with a clear wins, so the new log stays protected
      if (xfer_go)
        ee_status_reg <= 1'b1;
      else if (fl_clear)
        ee_status_reg <= 1'b0;
      if (fl_rest)
        ram_lock_reg <= 1'b1;
      else if (fl_clear | fault_log_read_done)
        ram_lock_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always @* begin
    rd_next  = 16'h0000;
    err_next = 1'b0;
    case (cmd_code)
      `CMD_SPARE_0, `CMD_SPARE_1, `CMD_SPARE_2, `CMD_SPARE_3:
        rd_next = spare_reg[spare_idx];
      `CMD_FACTORY_LOT:
        rd_next = {8'h00, `FACTORY_LOT_VALUE};
      `CMD_OFF_THRESH_COEF:
        rd_next = coef_reg[cmd_page];
      `CMD_SHARED_PIN_STAT: begin
        rd_next[`SHARED_CLK_LOW_BIT] = share_low_reg;
        rd_next[`SHARED_WP_BIT]      = wp_s;
      end
      `CMD_VOUT_MINIMUM: begin
        if (cmd_page[0] & current_mode[cmd_page]) begin
          rd_next  = `UNSUPPORTED_VALUE;
          err_next = 1'b1;
        end else begin
          rd_next = vout_min_reg[cmd_page];
        end
      end
      `CMD_VIN_MINIMUM:
        rd_next = vin_min_reg;
      `CMD_TEMP_MINIMUM:
        rd_next = temp_min_reg;
      `CMD_FLOG_STATUS: begin
        rd_next[`FLOG_EEPROM_BIT] = ee_status_reg;
        rd_next[`FLOG_RAM_BIT]    = ram_lock_reg;
      end
      default:
        err_next = 1'b1;
    endcase
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid <= 1'b0;
      rsp_data  <= 16'h0000;
      rsp_error <= 1'b0;
    end else begin
      rsp_valid <= cmd_valid & ~cmd_write;
      rsp_data  <= (cmd_valid & ~cmd_write) ? rd_next : 16'h0000;
      rsp_error <= cmd_valid & ~cmd_write & err_next &
                   ~(clr_fault | fl_store | fl_rest | fl_clear | usr_store | usr_rest);
    end
  end

endmodule

// ### tb/fault_log_checker.sv
// Port level assertions for the fault log and minimum telemetry group
`timescale 1ns/10ps
`include "fault_log_min_defines.vh"
module fault_log_checker (
  input wire        ref_clk,
  input wire        rst_b,
  input wire        cmd_valid,
  input wire        cmd_write,
  input wire [7:0]  cmd_code,
  input wire        rsp_valid,
  input wire [15:0] rsp_data,
  input wire        rsp_error,
  input wire        adc_valid,
  input wire [7:0]  on_cmd,
  input wire [7:0]  chan_on,
  input wire [7:0]  discharge_status,
  input wire        alert_n,
  input wire        fault_latch_off,
  input wire        fault_log_enable,
  input wire        ram_log_we,
  input wire        ee_write_req,
  input wire        ee_read_req,
  input wire        ee_erase_req
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  sequence rd_of(c);
    cmd_valid && !cmd_write && cmd_code == c;
  endsequence
  sequence disch_rise;
    (discharge_status & ~$past(discharge_status)) != 8'h00;
  endsequence
  lot_read_a: assert property (rd_of(`CMD_FACTORY_LOT) |=> rsp_valid && !rsp_error &&
    rsp_data == {8'h00, `FACTORY_LOT_VALUE})
    else $error("factory lot read wrong");
  common_rsv_a: assert property (rd_of(`CMD_SHARED_PIN_STAT) |=> rsp_valid && rsp_data[15:2] == 14'h0000)
    else $error("shared status reserved bits set");
  flag_alert_a: assert property (disch_rise |=> !alert_n)
    else $error("alert not low after discharge flag");
  alert_level_a: assert property (alert_n == ($past(discharge_status) == 8'h00))
    else $error("alert level does not follow flags");
  // A channel may only start on a command or on a fresh low reading
  on_cause_a: assert property ((chan_on & ~$past(chan_on)) != 8'h00 |-> $past(on_cmd != 8'h00) || $past(adc_valid) ||
    $past(adc_valid, 2))
    else $error("channel started without cause");
  log_enable_a: assert property (ee_write_req |-> $past(fault_log_enable))
    else $error("log transfer while disabled");
  log_cause_a: assert property (ee_write_req |-> $past(fault_latch_off || cmd_valid && !cmd_write &&
    cmd_code == `CMD_FLOG_STORE))
    else $error("log transfer without fault or store");
  restore_req_a: assert property (ee_read_req == $past(cmd_valid && !cmd_write && cmd_code == `CMD_FLOG_RESTORE))
    else $error("restore request mismatch");
  erase_req_a: assert property (ee_erase_req == $past(cmd_valid && !cmd_write && cmd_code == `CMD_FLOG_CLEAR))
    else $error("erase request mismatch");
  ram_we_a: assert property (ram_log_we |-> $past(adc_valid))
    else $error("log buffer write without conversion");
endmodule
bind fault_log_and_min_telemetry fault_log_checker chk (.ref_clk, .rst_b, .cmd_valid, .cmd_write, .cmd_code,
  .rsp_valid, .rsp_data, .rsp_error, .adc_valid, .on_cmd, .chan_on, .discharge_status, .alert_n, .fault_latch_off,
  .fault_log_enable, .ram_log_we, .ee_write_req, .ee_read_req, .ee_erase_req);

// ### tb/pmbus_host_model.sv
// Host model issuing one command at a time on the command port
`timescale 1ns/10ps
module pmbus_host (
  input  wire        ref_clk,
  output reg         cmd_valid,
  output reg         cmd_write,
  output reg  [7:0]  cmd_code,
  output reg  [2:0]  cmd_page,
  output reg  [15:0] cmd_wdata,
  input  wire        rsp_valid,
  input  wire [15:0] rsp_data,
  input  wire        rsp_error
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_page = 3'h0;
    cmd_wdata = 16'h0000;
  end
  // Called just after an edge; the answer stands for the cycle after the command edge
  task xfer(input w, input [7:0] c, input [2:0] p, input [15:0] d, output [15:0] rd, output er, output ok);
    begin
      cmd_write = w;
      cmd_code = c;
      cmd_page = p;
      cmd_wdata = d;
      cmd_valid = 1'b1;
      @(posedge ref_clk);
      #1;
      rd = rsp_data;
      er = rsp_error;
      ok = rsp_valid;
      cmd_valid = 1'b0;
      cmd_code = ~c;
      cmd_wdata = ~d;
      @(posedge ref_clk);
      #1;
    end
  endtask
endmodule

// ### tb/fault_log_and_min_telemetry_test.sv
// Self-checking bench for the fault log and minimum telemetry group
`timescale 1ns/10ps
`include "fault_log_min_defines.vh"
module fault_log_and_min_telemetry_test;
  reg          ref_clk = 1'b0;
  reg          rst_b = 1'b0;
  reg          share_run = 1'b0;
  reg          share_clk_pin = 1'b0;
  reg          write_protect_pin = 1'b0;
  reg          adc_valid = 1'b0;
  reg  [3:0]   adc_sel = 4'h0;
  reg  [15:0]  adc_data = 16'h0000;
  reg  [127:0] vout_cmd_bus = {8{16'h1000}};
  reg  [7:0]   uv_enable = 8'hFF;
  reg  [7:0]   current_mode = 8'h00;
  reg          vin_off = 1'b0;
  reg  [7:0]   on_cmd = 8'h00;
  reg  [7:0]   off_cmd = 8'h00;
  reg          fault_latch_off = 1'b0;
  reg          fault_log_enable = 1'b0;
  reg          fault_log_read_done = 1'b0;
  wire         cmd_valid, cmd_write, rsp_valid, rsp_error, alert_n, ram_log_we, ee_write_req, ee_read_req, ee_erase_req;
  wire [7:0]   cmd_code, chan_on, discharge_status;
  wire [2:0]   cmd_page;
  wire [15:0]  cmd_wdata, rsp_data;
  integer      num_errors = 0;
  integer      samples_checked = 0;
  integer      seed = 32'hCEFE;
  integer      cycles = 0;
  integer      n_wr = 0, n_rd = 0, n_er = 0, n_we = 0;
  integer      vmin [0:9];
  integer      i, k;
  reg  [15:0]  rd;
  reg          er, ok;

  always #10 ref_clk = ~ref_clk;
  // The share clock runs free while enabled; otherwise a pin held low
  always #80 share_clk_pin = share_run ? ~share_clk_pin : 1'b0;

  fault_log_and_min_telemetry dut (.ref_clk, .rst_b, .cmd_valid, .cmd_write, .cmd_code, .cmd_page, .cmd_wdata,
    .rsp_valid, .rsp_data, .rsp_error, .share_clk_pin, .write_protect_pin, .adc_valid, .adc_sel, .adc_data,
    .vout_cmd_bus, .uv_enable, .current_mode, .vin_off, .on_cmd, .off_cmd, .chan_on, .discharge_status, .alert_n,
    .fault_latch_off, .fault_log_enable, .fault_log_read_done, .ram_log_we, .ee_write_req, .ee_read_req,
    .ee_erase_req);
  pmbus_host host (.ref_clk, .cmd_valid, .cmd_write, .cmd_code, .cmd_page, .cmd_wdata, .rsp_valid, .rsp_data,
    .rsp_error);

  // ----------------------------------------------------------------
  // Pulse counters and run limit
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    n_wr <= n_wr + ee_write_req;
    n_rd <= n_rd + ee_read_req;
    n_er <= n_er + ee_erase_req;
    n_we <= n_we + ram_log_we;
    if (cycles == 6000) begin
      num_errors = num_errors + 1;
      stop_test;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task stop_test;
    begin
      if (num_errors == 0 && samples_checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [8*12:1] what, input [15:0] exp, input [15:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task rdc(input [7:0] c, input [2:0] p, input [15:0] exp, input e);
    begin
      host.xfer(1'b0, c, p, 16'h0000, rd, er, ok);
      chk("read data", exp, rd);
      chk("read flags", {14'h0000, e, 1'b1}, {14'h0000, er, ok});
    end
  endtask
  task wr(input [7:0] c, input [2:0] p, input [15:0] d);
    host.xfer(1'b1, c, p, d, rd, er, ok);
  endtask
  task snd(input [7:0] c);
    begin
      host.xfer(1'b0, c, 3'h0, 16'h0000, rd, er, ok);
      chk("answer", 16'h0001, {15'h0000, ok});
    end
  endtask
  // Model tracks the lowest accepted reading; all bench VIN and temperature values are positive with a zero exponent
  task adc(input [3:0] s, input [15:0] d);
    begin
      adc_sel = s;
      adc_data = d;
      adc_valid = 1'b1;
      tick(1);
      adc_valid = 1'b0;
      adc_data = ~d;
      if ((s < 8 ? uv_enable[s[2:0]] && !(s[0] && current_mode[s[2:0]]) : s == 9 || !vin_off) && d < vmin[s])
        vmin[s] = d;
      tick(1);
    end
  endtask
  task pulse_in(input integer which);
    begin
      if (which == 0) fault_latch_off = 1'b1;
      else fault_log_read_done = 1'b1;
      tick(1);
      fault_latch_off = 1'b0;
      fault_log_read_done = 1'b0;
      tick(2);
    end
  endtask
  task clear_model;
    for (i = 0; i < 10; i = i + 1)
      vmin[i] = i < 8 ? 16'hFFFF : 16'h7BFF;
  endtask
  task check_mins;
    begin
      for (i = 0; i < 8; i = i + 1)
        rdc(`CMD_VOUT_MINIMUM, i, (i % 2 && current_mode[i]) ? 16'h0000 : vmin[i][15:0],
          i % 2 && current_mode[i]);
      rdc(`CMD_VIN_MINIMUM, 3'h0, vmin[8][15:0], 1'b0);
      rdc(`CMD_TEMP_MINIMUM, 3'h0, vmin[9][15:0], 1'b0);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clear_model;
    repeat (16) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    tick(1);
    check_mins;
    for (i = 0; i < 8; i = i + 1)
      rdc(`CMD_FACTORY_LOT, i, {8'h00, `FACTORY_LOT_VALUE}, 1'b0);
    rdc(`CMD_FLOG_STATUS, 3'h0, 16'h0000, 1'b0);
    rdc(8'hC7, 3'h0, 16'h0000, 1'b1);
    rdc(`CMD_OFF_THRESH_COEF, 3'h3, 16'hF801, 1'b0);
    wr(`CMD_OFF_THRESH_COEF, 3'h1, 16'h0002);
    rdc(`CMD_OFF_THRESH_COEF, 3'h1, 16'h0002, 1'b0);
    for (k = 0; k < 60; k = k + 1) begin
      uv_enable = $random(seed);
      current_mode = $random(seed);
      vin_off = $random(seed);
      adc({$random(seed)} % 10, {6'h00, 10'($random(seed))});
    end
    check_mins;
    snd(`CMD_CLEAR_FAULTS);
    clear_model;
    check_mins;
    for (k = 0; k < 4; k = k + 1) begin
      write_protect_pin = k[0];
      share_run = 1'b1;
      tick(8);
      rdc(`CMD_SHARED_PIN_STAT, 3'h0, {15'h0000, k[0]}, 1'b0);
    end
    share_run = 1'b0;
    tick(64);
    rdc(`CMD_SHARED_PIN_STAT, 3'h0, 16'h0003, 1'b0);
    wr(`CMD_SPARE_0, 3'h0, 16'hA5C3);
    wr(`CMD_SPARE_2, 3'h5, 16'h3C5A);
    snd(`CMD_STORE_USER_ALL);
    wr(`CMD_SPARE_0, 3'h0, 16'h0000);
    wr(`CMD_SPARE_2, 3'h5, 16'h0000);
    snd(`CMD_RESTORE_USER_ALL);
    rdc(`CMD_SPARE_0, 3'h0, 16'hA5C3, 1'b0);
    rdc(`CMD_SPARE_2, 3'h5, 16'h3C5A, 1'b0);
    // Channel 0 at half of 1000h must fall below 0800h; channel 1 has the check disabled
    uv_enable = 8'hFF;
    adc(4'h0, 16'hFFF0);
    fault_log_enable = 1'b1;
    on_cmd = 8'h03;
    tick(1);
    on_cmd = 8'h00;
    tick(1);
    chk("chan on", 16'h0002, {8'h00, chan_on});
    chk("discharge", 16'h0001, {8'h00, discharge_status});
    chk("alert", 16'h0000, {15'h0000, alert_n});
    adc(4'h0, 16'h0900);
    tick(1);
    chk("chan on", 16'h0002, {8'h00, chan_on});
    adc(4'h0, 16'h07FF);
    tick(1);
    chk("chan on", 16'h0003, {8'h00, chan_on});
    chk("log writes", 16'h0000, n_wr[15:0]);
    fault_log_enable = 1'b0;
    off_cmd = 8'h01;
    tick(1);
    off_cmd = 8'h00;
    tick(1);
    chk("chan on", 16'h0002, {8'h00, chan_on});
    snd(`CMD_CLEAR_FAULTS);
    clear_model;
    tick(1);
    chk("discharge", 16'h0000, {8'h00, discharge_status});
    chk("alert", 16'h0001, {15'h0000, alert_n});
    // Fault log: disabled store, store, locked fault, restore, read, clear
    snd(`CMD_FLOG_STORE);
    rdc(`CMD_FLOG_STATUS, 3'h0, 16'h0000, 1'b0);
    fault_log_enable = 1'b1;
    snd(`CMD_FLOG_STORE);
    rdc(`CMD_FLOG_STATUS, 3'h0, 16'h0001, 1'b0);
    pulse_in(0);
    chk("log writes", 16'h0001, n_wr[15:0]);
    snd(`CMD_FLOG_RESTORE);
    rdc(`CMD_FLOG_STATUS, 3'h0, 16'h0003, 1'b0);
    chk("log reads", 16'h0001, n_rd[15:0]);
    k = n_we;
    adc(4'h9, 16'h0010);
    chk("buffer", k[15:0], n_we[15:0]);
    pulse_in(1);
    rdc(`CMD_FLOG_STATUS, 3'h0, 16'h0001, 1'b0);
    adc(4'h9, 16'h0011);
    tick(1);
    chk("buffer", k[15:0] + 16'h0001, n_we[15:0]);
    snd(`CMD_FLOG_CLEAR);
    rdc(`CMD_FLOG_STATUS, 3'h0, 16'h0000, 1'b0);
    chk("log erases", 16'h0001, n_er[15:0]);
    pulse_in(0);
    rdc(`CMD_FLOG_STATUS, 3'h0, 16'h0001, 1'b0);
    chk("log writes", 16'h0002, n_wr[15:0]);
    stop_test;
  end
endmodule
